// [fopb_pkg.sv]
// package: flash map, option byte layout and protection constants
package fopb_pkg;
  // ==========================================
  // array geometry
  localparam int FOPB_PAGE_BYTES = 2048;
  localparam int FOPB_MAIN_PAGES = 64;
  localparam int FOPB_REGION_PAGES = 4;
  localparam int FOPB_REGIONS = 16;
  localparam int FOPB_OPT_COUNT = 8;
  // ==========================================
  // address map
  localparam logic [31:0] FOPB_ALIAS_BASE = 32'h0000_0000;
  localparam logic [31:0] FOPB_MAIN_BASE = 32'h0800_0000;
  localparam logic [31:0] FOPB_FACT_BASE = 32'h0804_0000;
  localparam logic [31:0] FOPB_USER_BASE = 32'h0804_0800;
  localparam logic [31:0] FOPB_BOOT_GUARD_END = 32'h0800_1FFF;
  localparam logic [31:0] FOPB_MAIN_SIZE = 32'h0002_0000;
  localparam logic [31:0] FOPB_PAGE_SIZE = 32'h0000_0800;
  // ==========================================
  // option byte offsets (byte address of each half-word)
  localparam logic [31:0] FOPB_READ_PROTECT_OPTION = 32'h0804_0800;
  localparam logic [31:0] FOPB_RESERVED_OPTION_ONE = 32'h0804_0802;
  localparam logic [31:0] FOPB_CUSTOMER_OPTION_TWO = 32'h0804_0804;
  localparam logic [31:0] FOPB_CUSTOMER_OPTION_THREE = 32'h0804_0806;
  localparam logic [31:0] FOPB_WRITE_PROTECT_LOW_REGIONS = 32'h0804_0808;
  localparam logic [31:0] FOPB_WRITE_PROTECT_HIGH_REGIONS = 32'h0804_080A;
  localparam logic [31:0] FOPB_UNUSED_OPTION_SIX = 32'h0804_080C;
  localparam logic [31:0] FOPB_RESERVED_OPTION_SEVEN = 32'h0804_080E;
  localparam logic [2:0] FOPB_IDX_READ_PROT = 3'h0;
  localparam logic [2:0] FOPB_IDX_WP_LOW = 3'h4;
  localparam logic [2:0] FOPB_IDX_WP_HIGH = 3'h5;
  localparam logic [7:0] FOPB_UNLOCK_VALUE = 8'hA5;
  localparam logic [7:0] FOPB_ERASED_BYTE = 8'hFF;
  localparam logic [15:0] FOPB_ERASED_HALF = 16'hFFFF;
  // ==========================================
  // reset-exit loader timing
  localparam logic [3:0] FOPB_LOAD_CYCLES = 4'h8;

  typedef enum logic [2:0]
  {
    FOPB_ST_LOAD_REQ = 3'b000,
    FOPB_ST_LOAD_WAIT = 3'b001,
    FOPB_ST_RUN = 3'b010,
    FOPB_ST_ERROR = 3'b011,
    FOPB_ST_MASS = 3'b100
  } fopb_state_t;

  typedef enum logic [1:0]
  {
    FOPB_OP_NONE = 2'b00,
    FOPB_OP_PROG = 2'b01,
    FOPB_OP_PAGE_ERASE = 2'b10,
    FOPB_OP_MASS_ERASE = 2'b11
  } fopb_op_t;

  // bus request from processor/debugger
  typedef struct packed
  {
    logic valid;
    logic fetch;
    logic [31:0] addr;
  } fopb_bus_req_t;

  // program/erase request
  typedef struct packed
  {
    fopb_op_t op;
    logic [31:0] addr;
    logic [15:0] data;
  } fopb_pe_req_t;

  // command to the array
  typedef struct packed
  {
    logic valid;
    fopb_op_t op;
    logic [1:0] blk;
    logic [16:0] offset;
    logic [15:0] data;
  } fopb_arr_cmd_t;
endpackage

// [fopb_top.sv]
// flash option byte loader, address mapping and protection logic
`timescale 1ns/1ps
// Function
// - main array 64 pages; info pages one each
// - whole-page erase, aligned half-word program only
// - normal boot aliases main at zero
// - factory page at fixed base, monitor aliases zero
// - user page mapped, instruction fetches refused
// - factory page never programmed in field
// - option upper byte is hardware inverse
// - inverse mismatch at reset exit halts core
// - sixteen four-page regions from bytes 4,5
// - write-protect bits active low
// - protection applies after reset, blocks program/erase
// - read protection off only for 0xA5
// - read protection constant until chip reset
// - debugger connect latches intrusion flag
// - intrusion cleared by chip reset, or by pin reset, detached
// - protection plus intrusion disconnects all flash
// - erasing byte 0 while protected mass-erases main
// - protection guards bottom four pages
// - bytes 2,3 loaded only; 6 ignored; 1,7 reserved
module fopb_top
  import fopb_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_pin_reset,
  // boot mode and debugger
  input wire logic i_monitor_boot,
  input wire logic i_dbg_connected,
  // bus access
  input wire fopb_bus_req_t i_bus_req,
  // program / erase request
  input wire logic i_pe_valid,
  input wire fopb_pe_req_t i_pe_req,
  // array read port for option loading
  input wire logic [15:0] i_arr_rdata,
  input wire logic i_arr_busy,
  // array control
  output fopb_arr_cmd_t o_arr_cmd,
  output logic [2:0] o_opt_rd_idx,
  // bus answer
  output logic o_bus_sel,
  output logic [1:0] o_bus_blk,
  output logic [16:0] o_bus_offset,
  output logic o_bus_err,
  // status
  output logic o_pe_fail,
  output logic o_pe_done,
  output logic o_core_halt,
  output logic o_read_prot,
  output logic o_intrusion,
  output logic o_opt_error,
  output logic [7:0] o_customer_two,
  output logic [7:0] o_customer_three
);
  // ==========================================
  // input synchronisers
  logic [1:0] dbg_sync_ff;
  logic [1:0] pin_sync_ff;
  logic [1:0] mon_sync_ff;
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dbg_sync_ff <= 2'h0;
      pin_sync_ff <= 2'h0;
      mon_sync_ff <= 2'h0;
    end
    else
    begin
      dbg_sync_ff <= {dbg_sync_ff[0], i_dbg_connected};
      pin_sync_ff <= {pin_sync_ff[0], i_pin_reset};
      mon_sync_ff <= {mon_sync_ff[0], i_monitor_boot};
    end
  end
  wire dbg_on = dbg_sync_ff[1];
  wire pin_rst = pin_sync_ff[1];

  // ==========================================
  // option loader
  fopb_state_t state_ff;
  fopb_state_t nxt_state;
  logic [2:0] idx_ff;
  logic [3:0] wait_ff;
  logic [7:0] opt_ff [FOPB_OPT_COUNT];
  logic mismatch_ff;
  logic monitor_ff;
  logic rp_ff;
  logic intr_ff;
  logic mass_go;
  wire inv_ok = (i_arr_rdata[15:8] == ~i_arr_rdata[7:0]);
  wire last_idx = (idx_ff == 3'h7);
  wire wait_done = (wait_ff == FOPB_LOAD_CYCLES);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      FOPB_ST_LOAD_REQ: nxt_state = FOPB_ST_LOAD_WAIT;
      FOPB_ST_LOAD_WAIT:
        if (wait_done && last_idx)
          nxt_state = (mismatch_ff || !inv_ok) ? FOPB_ST_ERROR : FOPB_ST_RUN;
        else if (wait_done)
          nxt_state = FOPB_ST_LOAD_REQ;
      FOPB_ST_RUN:
        if (mass_go)
          nxt_state = FOPB_ST_MASS;
      FOPB_ST_MASS:
        // busy only shows a cycle after a command leaves, so wait that out too
        if (!i_arr_busy && !o_arr_cmd.valid)
          nxt_state = FOPB_ST_RUN;
      FOPB_ST_ERROR: nxt_state = FOPB_ST_ERROR;
      default: nxt_state = FOPB_ST_ERROR;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_ff <= FOPB_ST_LOAD_REQ;
      idx_ff <= 3'h0;
      wait_ff <= 4'h0;
      mismatch_ff <= 1'b0;
      monitor_ff <= 1'b0;
      rp_ff <= 1'b1;
      for (int i = 0; i < FOPB_OPT_COUNT; i++)
        opt_ff[i] <= FOPB_ERASED_BYTE;
    end
    else
    begin
      state_ff <= nxt_state;
      wait_ff <= (state_ff == FOPB_ST_LOAD_WAIT && !wait_done) ? wait_ff + 4'h1 : 4'h0;
      if (state_ff == FOPB_ST_LOAD_REQ)
        monitor_ff <= mon_sync_ff[1];
      if (state_ff == FOPB_ST_LOAD_WAIT && wait_done)
      begin
        opt_ff[idx_ff] <= i_arr_rdata[7:0];
        mismatch_ff <= mismatch_ff | ~inv_ok;
        idx_ff <= idx_ff + 3'h1;
        if (idx_ff == FOPB_IDX_READ_PROT)
          rp_ff <= (i_arr_rdata[7:0] != FOPB_UNLOCK_VALUE);
      end
    end
  end

  // intrusion latch: chip reset, or pin reset with debugger detached, clears it
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      intr_ff <= 1'b0;
    else if (dbg_on)
      intr_ff <= 1'b1;
    else if (pin_rst)
      intr_ff <= 1'b0;
  end

  // ==========================================
  // address decode
  wire [31:0] ba = i_bus_req.addr;
  wire in_main_hi = (ba >= FOPB_MAIN_BASE) && (ba < FOPB_MAIN_BASE + FOPB_MAIN_SIZE);
  wire in_zero = (ba < FOPB_PAGE_SIZE) || (ba < FOPB_MAIN_SIZE && !monitor_ff);
  wire main_alias = in_zero && !monitor_ff;
  wire fact_alias = (ba < FOPB_PAGE_SIZE) && monitor_ff;
  wire in_fact = ((ba >= FOPB_FACT_BASE) && (ba < FOPB_USER_BASE)) || fact_alias;
  wire in_user = (ba >= FOPB_USER_BASE) && (ba < FOPB_USER_BASE + FOPB_PAGE_SIZE);
  wire in_main = in_main_hi || main_alias;
  wire running = (state_ff == FOPB_ST_RUN);
  wire flash_cut = rp_ff && intr_ff;
  wire fetch_bad = in_user && i_bus_req.fetch;
  wire hit = in_main || in_fact || in_user;
  wire bus_ok = i_bus_req.valid && hit && running && !flash_cut && !fetch_bad;
  wire [1:0] blk = in_main ? 2'h0 : (in_fact ? 2'h1 : 2'h2);
  wire [16:0] boff = in_main ? ba[16:0] : {6'h00, ba[10:0]};

  // ==========================================
  // program / erase checks
  wire [31:0] pa = i_pe_req.addr;
  wire p_main = (pa >= FOPB_MAIN_BASE) && (pa < FOPB_MAIN_BASE + FOPB_MAIN_SIZE);
  wire p_fact = (pa >= FOPB_FACT_BASE) && (pa < FOPB_USER_BASE);
  wire p_user = (pa >= FOPB_USER_BASE) && (pa < FOPB_USER_BASE + FOPB_PAGE_SIZE);
  wire [3:0] region = pa[16:13];
  wire [15:0] wp_n = {opt_ff[FOPB_IDX_WP_HIGH], opt_ff[FOPB_IDX_WP_LOW]};
  wire region_wp = !wp_n[region];
  wire boot_guard = rp_ff && (pa <= FOPB_BOOT_GUARD_END);
  wire is_prog = (i_pe_req.op == FOPB_OP_PROG);
  wire is_erase = (i_pe_req.op == FOPB_OP_PAGE_ERASE);
  wire misalign = is_prog && pa[0];
  wire bad_op = !(is_prog || is_erase);
  wire opt_area = p_user && (pa[10:0] < 11'h010);
  wire main_locked = p_main && (region_wp || boot_guard);
  wire pe_ok = running && !flash_cut && (p_main || p_user) && !p_fact &&
               !misalign && !bad_op && !main_locked;
  wire opt0_erase = pe_ok && is_erase && opt_area; // page holding byte 0
  assign mass_go = i_pe_valid && opt0_erase && rp_ff;
  // upper byte of option-area writes always regenerated from the data byte
  wire [15:0] wdata = opt_area ? {~i_pe_req.data[7:0], i_pe_req.data[7:0]} : i_pe_req.data;
  wire [16:0] poff = p_main ? pa[16:0] : {6'h00, pa[10:0]};

  fopb_arr_cmd_t nxt_cmd;
  always_comb
  begin
    nxt_cmd = '0;
    if (state_ff == FOPB_ST_MASS && !i_arr_busy && !o_arr_cmd.valid)
    begin
      nxt_cmd.valid = 1'b1;
      nxt_cmd.op = FOPB_OP_MASS_ERASE;
    end
    else if (i_pe_valid && pe_ok)
    begin
      nxt_cmd.valid = 1'b1;
      nxt_cmd.op = i_pe_req.op;
      nxt_cmd.blk = p_main ? 2'h0 : 2'h2;
      nxt_cmd.offset = is_erase ? (poff & ~17'h007FF) : poff;
      nxt_cmd.data = wdata;
    end
  end

  // ==========================================
  // output registers
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_arr_cmd <= '0;
      o_bus_sel <= 1'b0;
      o_bus_blk <= 2'h0;
      o_bus_offset <= 17'h00000;
      o_bus_err <= 1'b0;
      o_pe_fail <= 1'b0;
      o_pe_done <= 1'b0;
    end
    else
    begin
      o_arr_cmd <= nxt_cmd;
      o_bus_sel <= bus_ok;
      o_bus_blk <= blk;
      o_bus_offset <= boff;
      o_bus_err <= i_bus_req.valid && !bus_ok;
      o_pe_fail <= i_pe_valid && !pe_ok;
      o_pe_done <= i_pe_valid && pe_ok;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_core_halt <= 1'b1;
      o_read_prot <= 1'b1;
      o_intrusion <= 1'b0;
      o_opt_error <= 1'b0;
      o_opt_rd_idx <= 3'h0;
      o_customer_two <= FOPB_ERASED_BYTE;
      o_customer_three <= FOPB_ERASED_BYTE;
    end
    else
    begin
      o_core_halt <= (nxt_state != FOPB_ST_RUN) || (rp_ff && intr_ff);
      o_read_prot <= rp_ff;
      o_intrusion <= intr_ff;
      o_opt_error <= (nxt_state == FOPB_ST_ERROR);
      o_opt_rd_idx <= idx_ff;
      o_customer_two <= opt_ff[2];
      o_customer_three <= opt_ff[3];
    end
  end

  // ==========================================
  // checks
  fopb_err_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (state_ff == FOPB_ST_ERROR) |=> o_core_halt && o_opt_error)
    else $error("option error does not halt core");
  intr_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    $fell(intr_ff) |-> $past(pin_rst) && !$past(dbg_on))
    else $error("intrusion cleared without pin reset");
  flash_cut_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    flash_cut |=> !o_bus_sel)
    else $error("flash reachable while cut off");
  user_fetch_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_bus_req.valid && fetch_bad) |=> o_bus_err && !o_bus_sel)
    else $error("fetch from user page allowed");
  rp_const_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (state_ff == FOPB_ST_RUN) |=> $stable(rp_ff))
    else $error("read protection changed while running");
  wp_block_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_pe_valid && main_locked && state_ff == FOPB_ST_RUN) |=> o_pe_fail && !o_pe_done)
    else $error("protected region accepted");
  boot_guard_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_pe_valid && rp_ff && p_main && pa <= FOPB_BOOT_GUARD_END) |=> o_pe_fail)
    else $error("bottom pages writable under read protection");
  fact_prog_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (i_pe_valid && p_fact) |=> o_pe_fail)
    else $error("factory page written");
  inv_gen_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (nxt_cmd.valid && nxt_cmd.op == FOPB_OP_PROG && opt_area && state_ff == FOPB_ST_RUN)
    |=> o_arr_cmd.data[15:8] == ~o_arr_cmd.data[7:0])
    else $error("option inverse not generated");
  mass_a: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    mass_go |=> ##[0:20] (o_arr_cmd.valid && o_arr_cmd.op == FOPB_OP_MASS_ERASE))
    else $error("mass erase not issued");
  run_c: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
    state_ff == FOPB_ST_RUN);
  mass_c: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) mass_go);
  cut_c: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) flash_cut);
endmodule

// [fopb_flash_model.sv]
// flash array model: option half-word reads and busy after each command
`timescale 1ns/1ps
module fopb_flash_model
  import fopb_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // option contents and array control
  input wire logic [7:0][15:0] i_opts,
  input wire logic [2:0] i_opt_rd_idx,
  input wire fopb_arr_cmd_t i_arr_cmd,
  output logic [15:0] o_arr_rdata,
  output logic o_arr_busy
);
  logic [2:0] busy_cnt_ff;
  // ==========================
  // read port
  // each half-word holds the byte low and its inverse high
  assign o_arr_rdata = i_opts[i_opt_rd_idx];
  // ==========================
  // busy
  // any command keeps the array busy, so mass erase must wait
  assign o_arr_busy = busy_cnt_ff != 3'h0;
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      busy_cnt_ff <= 3'h0;
    else if (i_arr_cmd.valid)
      busy_cnt_ff <= 3'h5;
    else if (busy_cnt_ff != 3'h0)
      busy_cnt_ff <= busy_cnt_ff - 3'h1;
  end
endmodule

// [test_flash_option_byte_protection.sv]
// testbench: option loading, address map and protection
`timescale 1ns/1ps
module test_flash_option_byte_protection;
  import fopb_pkg::*;
  logic i_core_clk, i_arst_n, i_pin_reset, i_monitor_boot, i_dbg_connected, i_pe_valid;
  fopb_bus_req_t i_bus_req;
  fopb_pe_req_t i_pe_req;
  fopb_arr_cmd_t o_arr_cmd;
  logic [15:0] arr_rdata;
  logic arr_busy;
  logic [2:0] o_opt_rd_idx;
  logic o_bus_sel, o_bus_err, o_pe_fail, o_pe_done, o_core_halt;
  logic o_read_prot, o_intrusion, o_opt_error;
  logic [1:0] o_bus_blk;
  logic [16:0] o_bus_offset;
  logic [7:0] o_customer_two, o_customer_three;
  logic [7:0][15:0] opts, bad;
  int failures, checks_done, n;
  fopb_top fopb_top_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_pin_reset(i_pin_reset),
    .i_monitor_boot(i_monitor_boot), .i_dbg_connected(i_dbg_connected), .i_bus_req(i_bus_req),
    .i_pe_valid(i_pe_valid), .i_pe_req(i_pe_req), .i_arr_rdata(arr_rdata), .i_arr_busy(arr_busy),
    .o_arr_cmd(o_arr_cmd), .o_opt_rd_idx(o_opt_rd_idx), .o_bus_sel(o_bus_sel),
    .o_bus_blk(o_bus_blk), .o_bus_offset(o_bus_offset), .o_bus_err(o_bus_err),
    .o_pe_fail(o_pe_fail), .o_pe_done(o_pe_done), .o_core_halt(o_core_halt),
    .o_read_prot(o_read_prot), .o_intrusion(o_intrusion), .o_opt_error(o_opt_error),
    .o_customer_two(o_customer_two), .o_customer_three(o_customer_three));
  fopb_flash_model fopb_flash_model_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_opts(opts), .i_opt_rd_idx(o_opt_rd_idx), .i_arr_cmd(o_arr_cmd),
    .o_arr_rdata(arr_rdata), .o_arr_busy(arr_busy));
  // ==========================
  // helpers
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0][15:0] mk(input logic [7:0] b0, input logic [7:0] b4);
    logic [7:0][7:0] b;
    logic [7:0][15:0] r;
    b = {8'hFF, 8'hFF, 8'h7F, b4, 8'h34, 8'h12, 8'hFF, b0};
    for (int i = 0; i < 8; i++)
      r[i] = {~b[i], b[i]};
    return r;
  endfunction
  // answer is registered on the taking edge and stands for one cycle
  task automatic bus(input logic [31:0] a, input logic f, input logic sel, input logic [1:0] blk,
    input logic [16:0] off);
    @(negedge i_core_clk);
    i_bus_req <= '{valid: 1'b1, fetch: f, addr: a};
    @(negedge i_core_clk);
    i_bus_req.valid <= 1'b0;
    chk("bus_sel", 32'(sel), 32'(o_bus_sel));
    chk("bus_err", 32'(!sel), 32'(o_bus_err));
    if (sel)
    begin
      chk("bus_blk", 32'(blk), 32'(o_bus_blk));
      chk("bus_offset", 32'(off), 32'(o_bus_offset));
    end
  endtask
  task automatic pe(input fopb_op_t op, input logic [31:0] a, input logic [15:0] d, input logic ok,
    input logic [15:0] xd);
    logic [16:0] xo;
    xo = (a >= FOPB_USER_BASE) ? {6'h00, a[10:0]} : a[16:0];
    if (op == FOPB_OP_PAGE_ERASE)
      xo[10:0] = 11'h000;
    @(negedge i_core_clk);
    i_pe_valid <= 1'b1;
    i_pe_req <= '{op: op, addr: a, data: d};
    @(negedge i_core_clk);
    i_pe_valid <= 1'b0;
    chk("pe_done", 32'(ok), 32'(o_pe_done));
    chk("pe_fail", 32'(!ok), 32'(o_pe_fail));
    chk("cmd_valid", 32'(ok), 32'(o_arr_cmd.valid));
    if (ok)
    begin
      chk("cmd_op", 32'(op), 32'(o_arr_cmd.op));
      chk("cmd_blk", (a >= FOPB_USER_BASE) ? 32'h2 : 32'h0, 32'(o_arr_cmd.blk));
      chk("cmd_offset", 32'(xo), 32'(o_arr_cmd.offset));
    end
    if (ok && op == FOPB_OP_PROG)
      chk("cmd_data", 32'(xd), 32'(o_arr_cmd.data));
  endtask
  // load takes about eighty cycles; two hundred is a safe bound
  task automatic boot(input logic [7:0][15:0] o, input logic mon, input logic good);
    i_arst_n <= 1'b0;
    opts <= o;
    i_monitor_boot <= mon;
    repeat (10) @(negedge i_core_clk);
    chk("halt_rst", 32'h1, 32'(o_core_halt));
    chk("prot_rst", 32'h1, 32'(o_read_prot));
    i_arst_n <= 1'b1;
    n = 0;
    while (o_core_halt !== 1'b0 && n < 200)
    begin
      @(negedge i_core_clk);
      n++;
    end
    chk("halt_load", 32'(!good), 32'(o_core_halt));
    chk("opt_error", 32'(!good), 32'(o_opt_error));
  endtask
  // ==========================
  // clock and watchdog
  initial
  begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  initial
  begin
    #250000;
    failures++;
    end_of_test();
  end
  // ==========================
  // sequence
  initial
  begin
    {i_arst_n, i_pin_reset, i_monitor_boot, i_dbg_connected, i_pe_valid} = 5'h00;
    i_bus_req = '0;
    i_pe_req = '0;
    opts = '0;
    failures = 0;
    checks_done = 0;
    boot(mk(8'hA5, 8'hFE), 1'b0, 1'b1);
    chk("read_prot", 32'h0, 32'(o_read_prot));
    chk("cust_two", 32'h12, 32'(o_customer_two));
    chk("cust_three", 32'h34, 32'(o_customer_three));
    bus(32'h0000_0100, 1'b1, 1'b1, 2'h0, 17'h00100);
    bus(32'h0801_FFFE, 1'b0, 1'b1, 2'h0, 17'h1FFFE);
    bus(32'h0802_0000, 1'b0, 1'b0, 2'h0, 17'h00000);
    bus(32'h0804_0010, 1'b1, 1'b1, 2'h1, 17'h00010);
    bus(32'h0804_0800, 1'b0, 1'b1, 2'h2, 17'h00000);
    bus(32'h0804_0800, 1'b1, 1'b0, 2'h0, 17'h00000);
    pe(FOPB_OP_PROG, 32'h0800_0100, 16'h1111, 1'b0, 16'h0000);
    pe(FOPB_OP_PROG, 32'h0800_2000, 16'h1234, 1'b1, 16'h1234);
    pe(FOPB_OP_PAGE_ERASE, 32'h0801_E000, 16'h0000, 1'b0, 16'h0000);
    pe(FOPB_OP_PROG, 32'h0801_C000, 16'h5678, 1'b1, 16'h5678);
    pe(FOPB_OP_PROG, 32'h0800_2001, 16'h1234, 1'b0, 16'h0000);
    pe(FOPB_OP_PROG, 32'h0804_0000, 16'h1234, 1'b0, 16'h0000);
    pe(FOPB_OP_PROG, 32'h0804_0804, 16'h0055, 1'b1, 16'hAA55);
    pe(FOPB_OP_PROG, 32'h0804_0808, 16'h00FF, 1'b1, 16'h00FF);
    pe(FOPB_OP_PROG, 32'h0800_0100, 16'h1111, 1'b0, 16'h0000);
    chk("cust_held", 32'h12, 32'(o_customer_two));
    i_dbg_connected <= 1'b1;
    repeat (4) @(negedge i_core_clk);
    chk("intrusion", 32'h1, 32'(o_intrusion));
    bus(32'h0800_0000, 1'b0, 1'b1, 2'h0, 17'h00000);
    i_dbg_connected <= 1'b0;
    repeat (4) @(negedge i_core_clk);
    chk("intr_kept", 32'h1, 32'(o_intrusion));
    bad = mk(8'hA5, 8'hFF);
    bad[3] = 16'h0034;
    boot(bad, 1'b0, 1'b0);
    boot(mk(8'hFF, 8'h7F), 1'b1, 1'b1);
    chk("read_prot", 32'h1, 32'(o_read_prot));
    bus(32'h0000_0000, 1'b1, 1'b1, 2'h1, 17'h00000);
    bus(32'h0800_0000, 1'b0, 1'b1, 2'h0, 17'h00000);
    pe(FOPB_OP_PROG, 32'h0800_1FFE, 16'h1234, 1'b0, 16'h0000);
    pe(FOPB_OP_PROG, 32'h0800_2000, 16'h4321, 1'b1, 16'h4321);
    pe(FOPB_OP_PROG, 32'h0800_E000, 16'h1111, 1'b0, 16'h0000);
    pe(FOPB_OP_PAGE_ERASE, 32'h0804_0800, 16'hFFFF, 1'b1, 16'h0000);
    n = 0;
    while (!(o_arr_cmd.valid === 1'b1 && o_arr_cmd.op === FOPB_OP_MASS_ERASE) && n < 40)
    begin
      @(negedge i_core_clk);
      n++;
    end
    chk("mass_erase", 32'h1, 32'(n < 40));
    opts <= mk(8'hA5, 8'hFF);
    repeat (4) @(negedge i_core_clk);
    chk("prot_held", 32'h1, 32'(o_read_prot));
    i_dbg_connected <= 1'b1;
    repeat (4) @(negedge i_core_clk);
    chk("intrusion", 32'h1, 32'(o_intrusion));
    chk("halt_cut", 32'h1, 32'(o_core_halt));
    bus(32'h0800_0000, 1'b0, 1'b0, 2'h0, 17'h00000);
    bus(32'h0804_0800, 1'b0, 1'b0, 2'h0, 17'h00000);
    i_dbg_connected <= 1'b0;
    i_pin_reset <= 1'b1;
    repeat (4) @(negedge i_core_clk);
    i_pin_reset <= 1'b0;
    repeat (4) @(negedge i_core_clk);
    chk("intr_clear", 32'h0, 32'(o_intrusion));
    end_of_test();
  end
endmodule
